// [hdl/ctm_pkg.sv]
// package: register map, field layouts and types of the compact timer
package ctm_pkg;

  // ==========================================================
  // register map (byte addresses, one word per register)
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_OUT_CTRL = 8'h04;
  localparam logic [7:0] OFS_CMP_A = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_PRESCALE = 8'h14;

  // ==========================================================
  // field positions and reset values
  localparam int CTRL0_ON_BIT = 3;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  localparam logic [7:0] RST_OUT_CTRL = 8'h00;
  localparam logic [3:0] RST_CTRL0 = 4'h0;
  localparam logic [9:0] RST_CMP_A = 10'h000;
  localparam logic [7:0] RST_PRESCALE = 8'h00;

  // ==========================================================
  // counter geometry
  localparam int CNT_W = 10;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  localparam logic [10:0] FULL_PERIOD = 11'h400;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_UNDEF = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    FUNC_NONE = 2'b00,
    FUNC_LOW = 2'b01,
    FUNC_HIGH = 2'b10,
    FUNC_TOGGLE = 2'b11
  } out_func_t;

  typedef enum logic [2:0] {
    SEL_CTRL0 = 3'b000,
    SEL_OUT_CTRL = 3'b001,
    SEL_CMP_A = 3'b010,
    SEL_COUNT = 3'b011,
    SEL_FLAGS = 3'b100,
    SEL_PRESCALE = 3'b101,
    SEL_NONE = 3'b111
  } reg_sel_t;

  typedef struct packed {
    op_mode_t op_mode;
    out_func_t out_func;
    logic out_initial_level;
    logic out_invert;
    logic period_duty_swap;
    logic clear_source_select;
  } out_ctrl_t;

  typedef struct packed {
    logic tick;
    logic hit_a;
    logic hit_p;
  } cnt_evt_t;

endpackage

// [hdl/ctm_tick_gen.sv]
// tick generator: divides pclk into the timer counting clock
`timescale 1ns/1ps
`default_nettype none
module ctm_tick_gen import ctm_pkg::*; #(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [DIV_W-1:0] divide,
  output logic tick_q
);

  logic [DIV_W-1:0] div_cnt_q;
  logic [DIV_W-1:0] div_cnt_d;
  logic tick_d;

  // ==========================================================
  // one tick every divide+1 clocks while running
  always_comb begin
    div_cnt_d = div_cnt_q;
    tick_d = 1'b0;
    if (!run) begin
      div_cnt_d = '0;
    end else if (div_cnt_q >= divide) begin
      div_cnt_d = '0;
      tick_d = 1'b1;
    end else begin
      div_cnt_d = div_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule // ctm_tick_gen
`default_nettype wire

// [hdl/ctm_timer.sv]
// compact 10-bit timer with compare-match, pwm and timer modes behind apb
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ctm_timer import ctm_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timer_out_pin,
  output logic timer_out_oe
);

  // ==========================================================
  // address decode, shared by read and write paths
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [7:0] a8;
    a8 = a[7:0];
    if (a8 == OFS_CTRL0) begin
      decode = SEL_CTRL0;
    end else if (a8 == OFS_OUT_CTRL) begin
      decode = SEL_OUT_CTRL;
    end else if (a8 == OFS_CMP_A) begin
      decode = SEL_CMP_A;
    end else if (a8 == OFS_COUNT) begin
      decode = SEL_COUNT;
    end else if (a8 == OFS_FLAGS) begin
      decode = SEL_FLAGS;
    end else if (a8 == OFS_PRESCALE) begin
      decode = SEL_PRESCALE;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // ==========================================================
  // state
  out_ctrl_t out_ctrl_q, out_ctrl_d;
  logic module_on_q, module_on_d;
  logic [2:0] compare_p_value_q, compare_p_value_d;
  logic [9:0] compare_a_value_q, compare_a_value_d;
  logic [DIV_W-1:0] prescale_q, prescale_d;
  logic match_a_flag_q, match_a_flag_d;
  logic match_p_flag_q, match_p_flag_d;
  logic [9:0] cnt_q, cnt_d;
  logic on_prev_q, on_prev_d;
  logic out_state_q, out_state_d;
  logic pin_d, oe_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic tick;
  cnt_evt_t evt;

  logic wr_en;
  reg_sel_t wsel, rsel;
  logic on_rise;
  logic [9:0] cnt_inc;
  logic clear_cnt;
  logic set_a, set_p;
  logic [10:0] duty;
  logic pwm_active;
  logic pwm_level;
  logic is_pwm;

  // ==========================================================
  // counting clock
  ctm_tick_gen #(
    .DIV_W(DIV_W)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(module_on_q),
    .divide(prescale_q),
    .tick_q(tick)
  );

  // ==========================================================
  // comparators
  always_comb begin
    cnt_inc = cnt_q + 10'h001;
    evt.tick = tick;
    evt.hit_a = (cnt_inc == compare_a_value_q) && (compare_a_value_q != 10'h000);
    // P compares the top three bits; code 000 matches at wrap = overflow
    evt.hit_p = (cnt_inc[9:7] == compare_p_value_q) && (cnt_inc[6:0] == 7'h00);
  end

  // ==========================================================
  // counter clear and flag events per mode
  always_comb begin
    is_pwm = (out_ctrl_q.op_mode == MODE_PWM);
    on_rise = module_on_q && !on_prev_q;
    on_prev_d = module_on_q;
    clear_cnt = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    if (evt.tick) begin
      if (is_pwm) begin
        // period register clears, clear select ignored
        clear_cnt = out_ctrl_q.period_duty_swap ? evt.hit_a : evt.hit_p;
        set_a = evt.hit_a;
        set_p = evt.hit_p;
      end else if (out_ctrl_q.clear_source_select) begin
        clear_cnt = evt.hit_a;
        set_a = evt.hit_a;
      end else begin
        clear_cnt = evt.hit_p;
        set_a = evt.hit_a;
        set_p = evt.hit_p;
      end
    end
    cnt_d = cnt_q;
    if (on_rise) begin
      cnt_d = 10'h000;
    end else if (evt.tick) begin
      // without a clear the 10-bit counter wraps past 3FF by itself
      cnt_d = clear_cnt ? 10'h000 : cnt_inc;
    end
  end

  // ==========================================================
  // pwm waveform
  always_comb begin
    if (out_ctrl_q.period_duty_swap) begin
      duty = (compare_p_value_q == 3'b000) ? FULL_PERIOD : {1'b0, compare_p_value_q, 7'h00};
    end else begin
      duty = {1'b0, compare_a_value_q};
    end
    // counter never reaches period, so duty >= period stays active
    pwm_active = ({1'b0, cnt_q} < duty);
    case (out_ctrl_q.out_func)
      FUNC_NONE: pwm_level = 1'b0;
      FUNC_LOW: pwm_level = 1'b1;
      FUNC_HIGH: pwm_level = pwm_active;
      default: pwm_level = 1'b0;
    endcase
  end

  // ==========================================================
  // compare-match output state and pin drive
  always_comb begin
    out_state_d = out_state_q;
    if (on_rise) begin
      out_state_d = out_ctrl_q.out_initial_level;
    end else if (set_a && (out_ctrl_q.op_mode == MODE_CMP)) begin
      // only A matches move the pin
      case (out_ctrl_q.out_func)
        FUNC_LOW: out_state_d = 1'b0;
        FUNC_HIGH: out_state_d = 1'b1;
        FUNC_TOGGLE: out_state_d = !out_state_q;
        default: out_state_d = out_state_q;
      endcase
    end
    oe_d = 1'b1;
    if (out_ctrl_q.op_mode == MODE_TIMER) begin
      oe_d = 1'b0;
      pin_d = 1'b0;
    end else if (is_pwm) begin
      // initial level bit picks the active level
      pin_d = (pwm_level ? out_ctrl_q.out_initial_level : !out_ctrl_q.out_initial_level)
              ^ out_ctrl_q.out_invert;
    end else begin
      pin_d = out_state_q ^ out_ctrl_q.out_invert;
    end
  end

  // ==========================================================
  // apb slave: answer built in setup, pready in the access phase
  always_comb begin
    wsel = decode(paddr);
    rsel = decode(paddr);
    wr_en = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    pready_d = psel && !penable;
    pslverr_d = psel && !penable && (rsel == SEL_NONE);
    prdata_d = prdata;
    if (psel && !penable) begin
      prdata_d = 32'h0000_0000;
      if (rsel == SEL_CTRL0) begin
        prdata_d[3:0] = {module_on_q, compare_p_value_q};
      end else if (rsel == SEL_OUT_CTRL) begin
        prdata_d[7:0] = out_ctrl_q;
      end else if (rsel == SEL_CMP_A) begin
        prdata_d[9:0] = compare_a_value_q;
      end else if (rsel == SEL_COUNT) begin
        prdata_d[9:0] = cnt_q;
      end else if (rsel == SEL_FLAGS) begin
        prdata_d[1:0] = {match_p_flag_q, match_a_flag_q};
      end else if (rsel == SEL_PRESCALE) begin
        prdata_d[DIV_W-1:0] = prescale_q;
      end
    end
  end

  // ==========================================================
  // register writes and sticky flags (set wins over clear)
  always_comb begin
    out_ctrl_d = out_ctrl_q;
    module_on_d = module_on_q;
    compare_p_value_d = compare_p_value_q;
    compare_a_value_d = compare_a_value_q;
    prescale_d = prescale_q;
    match_a_flag_d = match_a_flag_q;
    match_p_flag_d = match_p_flag_q;
    if (wr_en) begin
      if (wsel == SEL_CTRL0) begin
        module_on_d = pwdata[CTRL0_ON_BIT];
        compare_p_value_d = pwdata[2:0];
      end else if (wsel == SEL_OUT_CTRL) begin
        out_ctrl_d = out_ctrl_t'(pwdata[7:0]);
      end else if (wsel == SEL_CMP_A) begin
        compare_a_value_d = pwdata[9:0];
      end else if (wsel == SEL_FLAGS) begin
        if (pwdata[FLAG_A_BIT]) begin
          match_a_flag_d = 1'b0;
        end
        if (pwdata[FLAG_P_BIT]) begin
          match_p_flag_d = 1'b0;
        end
      end else if (wsel == SEL_PRESCALE) begin
        prescale_d = pwdata[DIV_W-1:0];
      end
    end
    if (set_a) begin
      match_a_flag_d = 1'b1;
    end
    if (set_p) begin
      match_p_flag_d = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ctrl_q <= out_ctrl_t'(RST_OUT_CTRL);
      module_on_q <= RST_CTRL0[CTRL0_ON_BIT];
      compare_p_value_q <= RST_CTRL0[2:0];
      compare_a_value_q <= RST_CMP_A;
      prescale_q <= RST_PRESCALE[DIV_W-1:0];
      match_a_flag_q <= 1'b0;
      match_p_flag_q <= 1'b0;
      cnt_q <= 10'h000;
      on_prev_q <= 1'b0;
      out_state_q <= 1'b0;
      timer_out_pin <= 1'b0;
      timer_out_oe <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      out_ctrl_q <= out_ctrl_d;
      module_on_q <= module_on_d;
      compare_p_value_q <= compare_p_value_d;
      compare_a_value_q <= compare_a_value_d;
      prescale_q <= prescale_d;
      match_a_flag_q <= match_a_flag_d;
      match_p_flag_q <= match_p_flag_d;
      cnt_q <= cnt_d;
      on_prev_q <= on_prev_d;
      out_state_q <= out_state_d;
      timer_out_pin <= pin_d;
      timer_out_oe <= oe_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

endmodule // ctm_timer
`default_nettype wire

// [tb/compact_timer_output_modes_tb.sv]
// testbench: registers, compare, timer and pwm behaviour of the compact timer
`timescale 1ns/1ps
`default_nettype none
module compact_timer_output_modes_tb import ctm_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, pin, oe, er;
  int n_mismatch = 0, cmp_count = 0, hi;
  logic [7:0] cc [4] = '{8'h19, 8'h21, 8'h35, 8'h09};
  logic [3:0] e0 = 4'b1011, e1 = 4'b0101; // bit 3-i for compare row i, row 0 at msb
  logic [7:0] pc [9] = '{8'hA8, 8'hAC, 8'hA0, 8'h88, 8'h98, 8'hAA, 8'hA8, 8'hA9, 8'hA8};
  logic [9:0] pa [9] = '{32, 32, 32, 32, 32, 256, 200, 32, 32};
  logic [2:0] pp [9] = '{1, 1, 1, 1, 1, 1, 1, 1, 0};
  int pe [9] = '{256, 768, 768, 0, 1024, 512, 1024, 256, 32}; // pin-high cycles per 1024
  always #4 pclk = ~pclk;
  ctm_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_out_pin(pin), .timer_out_oe(oe));
  // ==========================================================
  // bus tasks and comparison
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so that no signal is assigned twice in a time step
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // stop, clear flags, program and start the timer
  task automatic go(input logic [7:0] c, input logic [9:0] a, input logic [2:0] p);
    apb(1'b1, OFS_CTRL0, {29'h0, p});
    apb(1'b1, OFS_FLAGS, 32'h3);
    apb(1'b1, OFS_CMP_A, {22'h0, a});
    apb(1'b1, OFS_OUT_CTRL, {24'h0, c});
    apb(1'b1, OFS_CTRL0, {28'h0, 1'b1, p});
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // test sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OFS_OUT_CTRL, 32'h0);
    rdc(OFS_FLAGS, 32'h0);
    rdc(8'h40, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, OFS_OUT_CTRL, 32'h5A);
    rdc(OFS_OUT_CTRL, 32'h5A);
    // a write with the low byte strobe clear is ignored
    pstrb <= 4'hE;
    apb(1'b1, OFS_OUT_CTRL, 32'hFF);
    pstrb <= 4'hF;
    rdc(OFS_OUT_CTRL, 32'h5A);
    // prescale read-back, then back to the fastest tick; counter idle since reset
    apb(1'b1, OFS_PRESCALE, 32'h3);
    rdc(OFS_PRESCALE, 32'h3);
    apb(1'b1, OFS_PRESCALE, 32'h0);
    rdc(OFS_COUNT, 32'h0);
    // compare mode, clear on A at 200 with P below A; then clear on P, timer mode, and A or P at zero
    for (int i = 0; i < 4; i++) begin
      go(cc[i], 10'd200, 3'h1);
      repeat (100) @(posedge pclk);
      chk(32'(pin), 32'(e0[3-i]));
      repeat (115) @(posedge pclk);
      chk(32'(pin), 32'(e1[3-i]));
      rdc(OFS_FLAGS, 32'h1);
      apb(1'b1, OFS_CTRL0, 32'h1);
      apb(1'b1, OFS_CTRL0, 32'h9);
      repeat (5) @(posedge pclk);
      chk(32'(pin), 32'(e0[3-i]));
    end
    go(8'h30, 10'd200, 3'h1);
    repeat (300) @(posedge pclk);
    chk(32'(pin), 32'h0);
    rdc(OFS_FLAGS, 32'h2);
    go(8'h30, 10'd100, 3'h1);
    repeat (150) @(posedge pclk);
    chk(32'(pin), 32'h1);
    rdc(OFS_FLAGS, 32'h3);
    go(8'hF0, 10'd100, 3'h1);
    repeat (150) @(posedge pclk);
    chk(32'(oe), 32'h0);
    rdc(OFS_FLAGS, 32'h3);
    go(8'h01, 10'd0, 3'h0);
    repeat (1100) @(posedge pclk);
    rdc(OFS_FLAGS, 32'h0);
    go(8'h00, 10'd0, 3'h0);
    repeat (1030) @(posedge pclk);
    rdc(OFS_FLAGS, 32'h2);
    // pwm: count cycles with the pin high over a whole number of periods
    for (int i = 0; i < 9; i++) begin
      go(pc[i], pa[i], pp[i]);
      repeat (20) @(posedge pclk);
      hi = 0;
      repeat (1024) begin
        @(posedge pclk);
        hi += int'(pin === 1'b1);
      end
      chk(32'(hi), 32'(pe[i]));
    end
    rdc(OFS_FLAGS, 32'h3);
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    report_and_stop();
  end
endmodule // compact_timer_output_modes_tb
`default_nettype wire

// [tb/ctm_timer_assertions.sv]
// checker: port-level properties of the compact timer
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_chk import ctm_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_out_pin,
  input wire logic timer_out_oe
);
  // ==========================================================
  // shadow of control writes, cycles since last write
  out_ctrl_t oc_q, oc_d;
  logic on_q, on_d;
  logic [2:0] qt_q, qt_d;
  logic wr, bad, qt, lvl, cmp, pwm;
  always_comb begin
    bad = (paddr > ADDR_W'(OFS_PRESCALE)) || (paddr[1:0] != 2'b00);
    wr = psel && penable && pready && pwrite && pstrb[0] && !bad;
    oc_d = (wr && paddr == ADDR_W'(OFS_OUT_CTRL)) ? out_ctrl_t'(pwdata[7:0]) : oc_q;
    on_d = (wr && paddr == ADDR_W'(OFS_CTRL0)) ? pwdata[CTRL0_ON_BIT] : on_q;
    qt_d = wr ? 3'h0 : ((qt_q == 3'h7) ? qt_q : qt_q + 3'h1);
    qt = (qt_q == 3'h7) && !wr; // settled config, no write pending
    lvl = timer_out_pin ^ oc_q.out_invert;
    cmp = qt && (oc_q.op_mode == MODE_CMP);
    pwm = qt && (oc_q.op_mode == MODE_PWM);
  end
  // shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_q <= out_ctrl_t'(8'h00);
      on_q <= 1'b0;
      qt_q <= 3'h0;
    end else begin
      oc_q <= oc_d;
      on_q <= on_d;
      qt_q <= qt_d;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_ERR: assert property (psel && penable && pready |-> pslverr == bad)
    else $error("pslverr does not match address decode");
  AST_OE_TMR: assert property (qt && oc_q.op_mode == MODE_TIMER |-> !timer_out_oe)
    else $error("pin driven in timer mode");
  AST_OE_ON: assert property (qt && oc_q.op_mode != MODE_TIMER |-> timer_out_oe)
    else $error("pin not driven in output mode");
  AST_PWM_OFF: assert property (pwm && oc_q.out_func == FUNC_NONE |-> lvl == !oc_q.out_initial_level)
    else $error("pwm forced inactive level wrong");
  AST_PWM_ON: assert property (pwm && oc_q.out_func == FUNC_LOW |-> lvl == oc_q.out_initial_level)
    else $error("pwm forced active level wrong");
  AST_CMP_NONE: assert property (cmp && oc_q.out_func == FUNC_NONE |=> $stable(timer_out_pin))
    else $error("pin moved with no-change function");
  AST_CMP_LOW: assert property (cmp && oc_q.out_func == FUNC_LOW && !lvl |=> !lvl)
    else $error("pin left low level in drive-low function");
  AST_CMP_HIGH: assert property (cmp && oc_q.out_func == FUNC_HIGH && lvl |=> lvl)
    else $error("pin left high level in drive-high function");
  AST_ON_INIT: assert property ($rose(on_q) && oc_q.op_mode == MODE_CMP |-> ##[0:3] lvl == oc_q.out_initial_level)
    else $error("enable did not load initial level");
  CV_PWM: cover property (pwm && oc_q.out_func == FUNC_HIGH);
  CV_TMR: cover property (qt && oc_q.op_mode == MODE_TIMER);
  CV_ERR: cover property (pslverr);
endmodule // ctm_timer_chk
bind ctm_timer ctm_timer_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_out_pin(timer_out_pin), .timer_out_oe(timer_out_oe));
`default_nettype wire
